// >>> tcm_pkg.sv
// Constants and state layout for the bus clock master and frame sync block
`default_nettype none
package tcm_pkg;
  // System clock period and the clock loss timeout
  localparam int CLK_NS  = 50;       // 20 MHz system clock
  localparam int LOSS_NS = 2000;     // Master clock silent this long = lost
  localparam logic [5:0] LOSS_CYC = 6'(LOSS_NS / CLK_NS);
  // Transceiver count and frame length
  localparam int NXCVR = 10;         // Network clock candidates
  localparam logic [7:0] FRAME_LAST = 8'hff; // Divide by 256
  // Register word indices
  localparam logic [2:0] IDX_SEL    = 3'h0; // 0x00 master clock select
  localparam logic [2:0] IDX_RDIV   = 3'h1; // 0x04 rate generator divisor
  localparam logic [2:0] IDX_STATE  = 3'h2; // 0x08 live state, read only
  localparam logic [2:0] IDX_ISTAT  = 3'h3; // 0x0c sticky events, w1c
  localparam logic [2:0] IDX_IMASK  = 3'h4; // 0x10 event mask
  // Select codes and reset values
  localparam logic [3:0] SEL_RATEGEN = 4'h0; // 1..10 pick a transceiver
  localparam logic [7:0] RDIV_RST    = 8'h04; // Half period of 5 cycles
  // Event bit positions
  localparam int EV_FRAME = 0;       // Frame sync started
  localparam int EV_LOSS  = 1;       // Selected master clock went silent

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [NXCVR-1:0] xs1;      // Synchroniser stage one
    logic [NXCVR-1:0] xs2;      // Synchroniser stage two
    logic [7:0]       rg_cnt;   // Rate generator divider count
    logic             rg_clk;   // Rate generator clock
    logic [3:0]       sel;      // Master clock select
    logic [7:0]       rdiv;     // Rate generator half period minus one
    logic             bit_clk;  // Bus bit clock out
    logic [7:0]       fs_cnt;   // Frame position counter
    logic             fsync;    // Bus frame sync out
    logic [5:0]       loss_cnt; // Cycles since the last master edge
    logic [1:0]       istat;    // Sticky events
    logic [1:0]       imask;    // Event mask
    logic             dp_we;    // Write data phase pending
    logic [2:0]       dp_idx;   // Word index of the data phase
    logic [31:0]      rdata;    // Read data for the data phase
  } tcm_state_t;
endpackage
`default_nettype wire

// >>> tcm_fsync_gen.sv
// Bus bit clock master multiplexer and frame sync generator, AHB-Lite slave
`default_nettype none
module tcm_fsync_gen
  import tcm_pkg::*;
(
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  // AHB-Lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic [31:0]           HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  // Transceiver network clocks, asynchronous
  input  wire logic [NXCVR-1:0] XCVR_NET_CLK,
  // Interchip bus timing outputs
  output logic                  BUS_BIT_CLOCK,
  output logic                  BUS_FRAME_SYNC,
  // Interrupt
  output logic                  IRQ
);

  tcm_state_t s_q;   // Registered state
  tcm_state_t s_d;   // Next state
  logic       sel_clk;   // Mux output before the output flop
  logic       clk_rise;  // Rising edge of the selected master
  logic [1:0] ev;        // Events this cycle
  logic [1:0] w1c;       // Event bits cleared by software
  logic       ap_take;   // Address phase accepted

  // Master clock mux; out of range codes fall back to the rate generator
  always_comb begin
    sel_clk = s_q.rg_clk;
    for (int i = 0; i < NXCVR; i++) begin
      if (s_q.sel == 4'(i + 1)) begin
        sel_clk = s_q.xs2[i];
      end
    end
  end

  // Edge seen against the previous output sample
  assign clk_rise = sel_clk & ~s_q.bit_clk;
  assign ap_take  = HSEL & HTRANS[1] & HREADY;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    ev  = 2'h0;
    w1c = 2'h0;
    // Two-flop synchronisers; stage one feeds stage two only
    s_d.xs1 = XCVR_NET_CLK;
    s_d.xs2 = s_q.xs1;
    // Rate generator, a toggle each rdiv+1 system cycles
    if (s_q.rg_cnt >= s_q.rdiv) begin
      s_d.rg_cnt = 8'h00;
      s_d.rg_clk = ~s_q.rg_clk;
    end else begin
      s_d.rg_cnt = s_q.rg_cnt + 8'h01;
    end
    // Bit clock passes the selected master through
    s_d.bit_clk = sel_clk;
    // Free-running divider, never parked on a master change
    if (clk_rise) begin
      s_d.fs_cnt = s_q.fs_cnt + 8'h01;
      // One bit clock wide pulse at each wrap of the divider
      s_d.fsync  = (s_q.fs_cnt == FRAME_LAST);
      if (s_q.fs_cnt == FRAME_LAST) begin
        ev[EV_FRAME] = 1'b1;
      end
    end
    // Silence watchdog on the selected master
    // A rate generator half period above 20 cycles also trips it
    if (clk_rise) begin
      s_d.loss_cnt = 6'h00;
    end else if (s_q.loss_cnt != LOSS_CYC) begin
      s_d.loss_cnt = s_q.loss_cnt + 6'h01;
      // Flag once, on reaching the limit
      ev[EV_LOSS] = (s_q.loss_cnt + 6'h01 == LOSS_CYC);
    end
    // Data phase write, applied before a read that follows it, except the select field of the state word
    if (s_q.dp_we) begin
      unique case (s_q.dp_idx)
        IDX_SEL:   s_d.sel   = HWDATA[3:0];
        IDX_RDIV:  s_d.rdiv  = HWDATA[7:0];
        IDX_ISTAT: w1c       = HWDATA[1:0];
        IDX_IMASK: s_d.imask = HWDATA[1:0];
        default:   ; // Read only or unmapped, ignored
      endcase
    end
    // Set wins over a clear in the same cycle
    s_d.istat = (s_q.istat & ~w1c) | ev;
    // Address phase capture; writes outside the map must not alias
    // onto a register through the low address bits
    s_d.dp_we  = ap_take & HWRITE & (HADDR[31:5] == 27'h0);
    s_d.dp_idx = HADDR[4:2];
    if (ap_take & ~HWRITE) begin
      // Unmapped words read as zero
      if (HADDR[31:5] != 27'h0) begin
        s_d.rdata = 32'h0;
      end else begin
        unique case (HADDR[4:2])
          IDX_SEL:   s_d.rdata = {28'h0, s_d.sel};
          IDX_RDIV:  s_d.rdata = {24'h0, s_d.rdiv};
          // Live state word: sync, bit clock, counter, select
          IDX_STATE: s_d.rdata = {18'h0, s_q.fsync, s_q.bit_clk,
                                  s_q.fs_cnt, s_q.sel};
          IDX_ISTAT: s_d.rdata = {30'h0, s_d.istat};
          IDX_IMASK: s_d.rdata = {30'h0, s_d.imask};
          default:   s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // State register; reset picks the rate generator and clears the divider
  // Reset branch assigns constants only
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q        <= '0;
      s_q.sel    <= SEL_RATEGEN;
      s_q.rdiv   <= RDIV_RST;
      s_q.fs_cnt <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; zero wait states, always OKAY
  assign HRDATA         = s_q.rdata;
  assign HREADYOUT      = 1'b1;
  assign HRESP          = 1'b0;
  assign BUS_BIT_CLOCK  = s_q.bit_clk;
  assign BUS_FRAME_SYNC = s_q.fsync;
  assign IRQ            = |(s_q.istat & s_q.imask);

  // Helpers for the checks below: edges since the last frame sync
  logic [8:0] h_edges;  // Bit clock rises since frame sync rose
  logic       h_seen;   // A frame sync has been seen
  logic       h_rst_q;  // Reset delayed one cycle
  always_ff @(posedge CLK_SYS) begin
    h_rst_q <= RST;
    if (RST) begin
      h_edges <= 9'h0;
      h_seen  <= 1'b0;
    end else if ($rose(BUS_FRAME_SYNC)) begin
      h_edges <= 9'h0;
      h_seen  <= 1'b1;
    end else if ($rose(BUS_BIT_CLOCK)) begin
      h_edges <= h_edges + 9'h1;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_fsync_period: assert property (
    ($rose(BUS_FRAME_SYNC) && h_seen) |-> h_edges == 9'd255)
    else $error("Frame sync period is not 256 bit clocks");
  a_fsync_rise_align: assert property (
    $rose(BUS_FRAME_SYNC) |-> $rose(BUS_BIT_CLOCK))
    else $error("Frame sync rose away from a bit clock rise");
  a_fsync_one_wide: assert property (
    $fell(BUS_FRAME_SYNC) |-> $rose(BUS_BIT_CLOCK) && h_edges == 9'd0)
    else $error("Frame sync not one bit clock wide");
  a_bit_clk_path: assert property (
    BUS_BIT_CLOCK == $past(sel_clk))
    else $error("Bit clock does not follow the selected master");
  a_mux_rategen: assert property (
    (s_q.sel == SEL_RATEGEN) [*2] |-> BUS_BIT_CLOCK == $past(s_q.rg_clk))
    else $error("Rate generator not routed to the bit clock");
  a_mux_xcvr_one: assert property (
    (s_q.sel == 4'h1) [*2] |-> BUS_BIT_CLOCK == $past(s_q.xs2[0]))
    else $error("First transceiver clock not routed");
  a_count_free: assert property (
    clk_rise |=> s_q.fs_cnt == $past(s_q.fs_cnt) + 8'h01)
    else $error("Frame counter did not advance on a master edge");
  a_reset_state: assert property (
    h_rst_q |-> s_q.sel == SEL_RATEGEN && s_q.fs_cnt == 8'h00
      && !BUS_FRAME_SYNC)
    else $error("Reset did not select the rate generator");
  a_loss_flag: assert property (
    (s_q.loss_cnt == LOSS_CYC - 6'h01 && !clk_rise) |=> s_q.istat[EV_LOSS])
    else $error("Master clock loss not flagged");
  a_frame_event: assert property (
    $rose(BUS_FRAME_SYNC) |-> s_q.istat[EV_FRAME])
    else $error("Frame sync start not flagged");

  // Covers for the main scenarios: sync, switch, loss, interrupt
  c_frame_sync: cover property ($rose(BUS_FRAME_SYNC));
  c_xcvr_master: cover property (s_q.sel == 4'h1 && clk_rise);
  c_master_switch: cover property (
    s_q.sel == SEL_RATEGEN ##1 s_q.sel != SEL_RATEGEN);
  c_clock_loss: cover property ($rose(s_q.istat[EV_LOSS]));
  c_irq: cover property ($rose(IRQ));

endmodule
`default_nettype wire

// >>> tcm_xcvr_model.sv
// Behavioural transceiver network clock sources
`default_nettype none
module tcm_xcvr_model
  import tcm_pkg::*;
(
  // Activation state per transceiver
  input  wire logic [NXCVR-1:0] en,
  // Bus frame sync seen by every transceiver
  input  wire logic             fsync,
  // Network clocks toward the block
  output logic [NXCVR-1:0]      net_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ck;   // Shared near 2.048 MHz reference
  logic live; // Bus timing has reached the transceivers
  // Slaves need bus timing before their clock can start
  initial live = 1'h0;
  always @(posedge fsync) live = 1'h1;
  // Free source, about 2.049 MHz
  initial begin
    ck = 1'h0;
    forever #244 ck = ~ck;
  end
  // Clock only while active; stands low otherwise
  assign net_clk = live ? (en & {NXCVR{ck}}) : '0;
endmodule
`default_nettype wire

// >>> tcm_fsync_gen_tb.sv
// Testbench for the bus clock master and frame sync block
`default_nettype none
module tcm_fsync_gen_tb
  import tcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rst, hsel, hwrite, bck, fsy, irq, hro, hrs;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, hrdata, rd, r, r2;
  logic [NXCVR-1:0] xen, xclk;
  int               n_fail, tests_run, cyc, per, wid;
  tcm_fsync_gen tcm_fsync_gen_inst (.CLK_SYS(clk), .RST(rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro), .HRDATA(hrdata),
    .HREADYOUT(hro), .HRESP(hrs), .XCVR_NET_CLK(xclk),
    .BUS_BIT_CLOCK(bck), .BUS_FRAME_SYNC(fsy), .IRQ(irq));
  tcm_xcvr_model tcm_xcvr_model_inst (.en(xen), .fsync(fsy),
    .net_clk(xclk));
  // 20 MHz system clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      test_done();
    end
  end
  // Count and report one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected sync width in system cycles: one rate generator period
  function automatic logic [31:0] sync_width(input logic [31:0] half);
    sync_width = 32'h2 * (half + 32'h1);
  endfunction
  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hro !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hro !== 1'h1);
    rd = hrdata;
  endtask
  // Bit clock rises per frame and sync width in system cycles
  task automatic frame();
    logic pb, pf;
    while (fsy !== 1'h0) @(posedge clk);
    while (fsy !== 1'h1) @(posedge clk);
    pb = 1'h1;
    per = 0;
    wid = 1;
    do begin
      pf = fsy;
      @(posedge clk);
      if (bck === 1'h1 && pb !== 1'h1) per++;
      if (fsy === 1'h1 && per == 0) wid++;
      pb = bck;
    end while (!(fsy === 1'h1 && pf === 1'h0));
  endtask
  // Counts, verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, hsel, htrans, hwrite, haddr, hwdata, xen} = '0;
    rst = 1'h1;
    {n_fail, tests_run, cyc} = '0;
    r = $urandom(94190);
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    chk(32'(irq), 32'h0);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'(SEL_RATEGEN));
    bus(1'h0, 8'h04, 32'h0);
    chk(rd, 32'(RDIV_RST));
    $display("reset test ended");
    // Rate generator master: fastest, random, then the reset divisor
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 32'h0 : 32'($urandom_range(3, 1));
      if (i == 2) r = 32'(RDIV_RST);
      bus(1'h1, 8'h04, r);
      frame();
      chk(32'(per), 32'h100);
      chk(32'(wid), sync_width(r));
    end
    $display("rate generator test ended");
    // First, then a random transceiver becomes master; sync tracks it
    xen <= '1;
    bus(1'h1, 8'h04, 32'h1);
    for (int i = 0; i < 2; i++) begin
      r = (i == 0) ? 32'h1 : 32'($urandom_range(NXCVR, 1));
      bus(1'h1, 8'h00, r);
      bus(1'h0, 8'h08, 32'h0);
      chk(32'(rd[3:0]), r);
      frame();
      chk(32'(per), 32'h100);
      chk(32'(wid == 9 || wid == 10), 32'h1);
    end
    $display("transceiver test ended");
    // Frame event: raise, mask, clear
    bus(1'h1, 8'h0c, 32'h3);
    bus(1'h1, 8'h10, 32'h1);
    while (irq !== 1'h1) @(posedge clk);
    bus(1'h0, 8'h0c, 32'h0);
    chk(32'(rd[0]), 32'h1);
    bus(1'h1, 8'h10, 32'h0);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'h1, 8'h0c, 32'h1);
    bus(1'h0, 8'h0c, 32'h0);
    chk(32'(rd[0]), 32'h0);
    $display("interrupt test ended");
    // Master hands over, then every clock stops; silence flagged
    bus(1'h1, 8'h10, 32'h2);
    r2 = 32'(r % NXCVR + 1);
    bus(1'h1, 8'h00, r2);
    xen <= ~(NXCVR'(1) << (r - 1));
    repeat (60) @(posedge clk);
    chk(32'(irq), 32'h0);
    xen <= '0;
    repeat (60) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1'h0, 8'h0c, 32'h0);
    chk(32'(rd[1]), 32'h1);
    $display("clock loss test ended");
    // Read-only write ignored, unmapped read gives zero
    bus(1'h1, 8'h08, 32'h0);
    bus(1'h1, 8'h20, 32'h0);
    bus(1'h0, 8'h00, 32'h0);
    chk(32'(rd[3:0]), r2);
    bus(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("map test ended");
    test_done();
  end
endmodule
`default_nettype wire
